/* File: logic/flash_cmd_pkg.sv */
// Shared constants and types of the flash command executor
package flash_cmd_pkg;

    // Register byte offsets on the register bus
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_INDEX  = 8'h04;
    localparam logic [7:0] OFS_WORD   = 8'h08;

    // Bit positions in the flash status register
    localparam int BIT_DONE = 7;
    localparam int BIT_ACC  = 5;
    localparam int BIT_VIOL = 4;
    localparam int BIT_VERR = 1;
    localparam int BIT_UNC  = 0;

    // Values after reset
    localparam logic [7:0]  STATUS_RST = 8'h80;
    localparam logic [2:0]  INDEX_RST  = 3'h0;
    localparam logic [15:0] WORD_RST   = 16'h0000;

    // Command codes
    localparam logic [7:0] CMD_PROG  = 8'h06;
    localparam logic [7:0] CMD_OTP   = 8'h07;
    localparam logic [7:0] CMD_ERALL = 8'h08;
    localparam logic [7:0] CMD_ERBLK = 8'h09;
    localparam logic [7:0] CMD_ERSEC = 8'h0A;
    localparam logic [7:0] CMD_UNSEC = 8'h0B;

    // Command word indices and limits
    localparam logic [2:0]  IDX_CODE  = 3'h0;
    localparam logic [2:0]  IDX_ADDR  = 3'h1;
    localparam logic [2:0]  IDX_DATA  = 3'h5;
    localparam int          NUM_WORDS = 6;
    localparam logic [15:0] OTP_MAX   = 16'h0007;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Operations requested from the flash array sequencer
    typedef enum logic [2:0] {
        OP_PROG,
        OP_OTP_BLANK,
        OP_OTP_PROG,
        OP_ERASE_BLOCK,
        OP_ERASE_SECTOR,
        OP_ERASE_ALL
    } op_kind_type;

    // Command executor states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CHECK,
        ST_BLANK,
        ST_RUN
    } state_type;

endpackage

/* File: logic/flash_cmd_exec.sv */
// Flash command executor with its register slave on AXI4-Lite
// What this block does
// RULE_01: Phrase program needs last index 5 and mode permission, else access error.
// RULE_02: Phrase program address invalid or not phrase aligned gives access error.
// RULE_03: Phrase program into protected area gives protection violation, no program.
// RULE_04: Verify errors set verify flag; uncorrectable ones set uncorrectable flag.
// RULE_05: Host loads one-time code, phrase index 0 to 7, four data words.
// RULE_06: One-time program checks blank first, then programs and verifies.
// RULE_07: One-time errors: bad index, bad phrase, already programmed; never violation.
// RULE_08: A phrase programmed all ones counts as blank and may be programmed.
// RULE_09: Block 0 reads may be invalid while one-time program runs.
// RULE_10: Erase all erases everything, verifies, releases security on pass.
// RULE_11: Erase all and unsecure need index 0 and no protection anywhere.
// RULE_12: Host writes no flash register while erase all or unsecure runs.
// RULE_13: Host loads block erase code, upper address, then lower address.
// RULE_14: Block erase checks index 1, address valid and aligned per flash type.
// RULE_15: Block erase on protected block gives violation, else erase and verify.
// RULE_16: Sector erase erases the addressed sector and verifies it.
// RULE_17: Sector erase checks index 1, valid address, phrase alignment, protection.
// RULE_18: Unsecure erases everything, verifies, releases security on pass.
// RULE_19: Failed unsecure verify sets verify flag, security left unchanged.
// RULE_20: Clearing the done flag launches; it stays clear until finished.
// RULE_21: Host loads program code, upper address, phrase address, four words.
// RULE_22: Phrase program writes four words then reads them back to verify.
// RULE_23: Mode availability row input decides which commands may launch.
// RULE_24: A failed launch check starts nothing and sets done at once.
`timescale 1ns/10ps
module flash_cmd_exec #(
    parameter int ADDR_W = 8
) (
    input  wire logic                      clk_i,
    input  wire logic                      sys_rst_i,
    input  wire logic [ADDR_W-1:0]         s_axi_awaddr_i,
    input  wire logic                      s_axi_awvalid_i,
    output logic                           s_axi_awready_o,
    input  wire logic [31:0]               s_axi_wdata_i,
    input  wire logic [3:0]                s_axi_wstrb_i,
    input  wire logic                      s_axi_wvalid_i,
    output logic                           s_axi_wready_o,
    output logic [1:0]                     s_axi_bresp_o,
    output logic                           s_axi_bvalid_o,
    input  wire logic                      s_axi_bready_i,
    input  wire logic [ADDR_W-1:0]         s_axi_araddr_i,
    input  wire logic                      s_axi_arvalid_i,
    output logic                           s_axi_arready_o,
    output logic [31:0]                    s_axi_rdata_o,
    output logic [1:0]                     s_axi_rresp_o,
    output logic                           s_axi_rvalid_o,
    input  wire logic                      s_axi_rready_i,
    input  wire logic [15:0]               cmd_allow_i,
    output logic [22:0]                    chk_addr_o,
    output flash_cmd_pkg::op_kind_type     chk_kind_o,
    input  wire logic                      chk_addr_valid_i,
    input  wire logic                      chk_pflash_i,
    input  wire logic                      chk_prot_i,
    input  wire logic                      any_prot_i,
    output logic                           op_start_o,
    output flash_cmd_pkg::op_kind_type     op_kind_o,
    output logic [22:0]                    op_addr_o,
    output logic [63:0]                    op_data_o,
    input  wire logic                      op_done_i,
    input  wire logic                      op_verr_i,
    input  wire logic                      op_uncorr_i,
    output logic                           secure_release_o,
    output logic                           block0_busy_o
);

    // Byte-lane merge into a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0]  s);
        merge16 = old;
        if (s[0]) merge16[7:0] = d[7:0];
        if (s[1]) merge16[15:8] = d[15:8];
    endfunction

    flash_cmd_pkg::state_type   state_reg, state_next;
    flash_cmd_pkg::op_kind_type kind_reg, kind_next;
    logic [7:0]  stat_reg, stat_next;
    logic [2:0]  index_reg, index_next;
    logic [15:0] word_reg [flash_cmd_pkg::NUM_WORDS];
    logic [15:0] word_next [flash_cmd_pkg::NUM_WORDS];
    logic        aw_have_reg, aw_have_next;
    logic        w_have_reg, w_have_next;
    logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0]  wstrb_reg, wstrb_next;
    logic        bvalid_reg, bvalid_next;
    logic [1:0]  bresp_reg, bresp_next;
    logic        rvalid_reg, rvalid_next;
    logic [1:0]  rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        start_reg, start_next;
    logic [22:0] opaddr_reg, opaddr_next;
    logic [63:0] opdata_reg, opdata_next;
    logic        release_reg, release_next;
    logic        b0busy_reg, b0busy_next;
    logic        do_write, launch, busy, acc_chk, viol_chk;
    logic [7:0]  code;
    logic [22:0] gaddr;
    logic [7:0]  wofs;

    // Command fields seen by the checks
    assign code  = word_reg[0][15:8];
    assign gaddr = {word_reg[0][6:0], word_reg[1]};
    assign busy  = !stat_reg[flash_cmd_pkg::BIT_DONE];
    assign wofs  = 8'(awaddr_reg);
    assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;
    // Access and violation errors must be cleared before a new launch is accepted
    assign launch = do_write && wofs == flash_cmd_pkg::OFS_STATUS
                    && wstrb_reg[0]
                    && wdata_reg[flash_cmd_pkg::BIT_DONE] && !busy
                    && !stat_reg[flash_cmd_pkg::BIT_ACC]
                    && !stat_reg[flash_cmd_pkg::BIT_VIOL];

    // Protection query target follows the command code
    always_comb
    begin
        chk_addr_o = gaddr;
        case (code)
            flash_cmd_pkg::CMD_ERBLK: chk_kind_o = flash_cmd_pkg::OP_ERASE_BLOCK;
            flash_cmd_pkg::CMD_ERSEC: chk_kind_o = flash_cmd_pkg::OP_ERASE_SECTOR;
            flash_cmd_pkg::CMD_ERALL,
            flash_cmd_pkg::CMD_UNSEC: chk_kind_o = flash_cmd_pkg::OP_ERASE_ALL;
            flash_cmd_pkg::CMD_OTP:   chk_kind_o = flash_cmd_pkg::OP_OTP_PROG;
            default:                  chk_kind_o = flash_cmd_pkg::OP_PROG;
        endcase
    end

    // Launch checks; unknown codes are refused as access errors
    always_comb
    begin
        acc_chk  = !cmd_allow_i[code[3:0]] || code[7:4] != 4'h0; // RULE_23
        viol_chk = 1'b0;
        case (code)
            flash_cmd_pkg::CMD_PROG:
            begin
                acc_chk = acc_chk || index_reg != flash_cmd_pkg::IDX_DATA
                          || !chk_addr_valid_i
                          || gaddr[2:0] != 3'h0; // RULE_01 RULE_02
                viol_chk = chk_prot_i; // RULE_03
            end
            flash_cmd_pkg::CMD_OTP:
                acc_chk = acc_chk || index_reg != flash_cmd_pkg::IDX_DATA
                          || word_reg[1] > flash_cmd_pkg::OTP_MAX; // RULE_07
            flash_cmd_pkg::CMD_ERALL, flash_cmd_pkg::CMD_UNSEC:
            begin
                acc_chk = acc_chk
                          || index_reg != flash_cmd_pkg::IDX_CODE; // RULE_11
                viol_chk = any_prot_i; // RULE_11
            end
            flash_cmd_pkg::CMD_ERBLK:
            begin
                acc_chk = acc_chk || index_reg != flash_cmd_pkg::IDX_ADDR
                          || !chk_addr_valid_i
                          || (chk_pflash_i ? gaddr[2:0] != 3'h0
                                           : gaddr[0]); // RULE_14
                viol_chk = chk_prot_i; // RULE_15
            end
            flash_cmd_pkg::CMD_ERSEC:
            begin
                acc_chk = acc_chk || index_reg != flash_cmd_pkg::IDX_ADDR
                          || !chk_addr_valid_i
                          || gaddr[2:0] != 3'h0; // RULE_17
                viol_chk = chk_prot_i; // RULE_17
            end
            default: acc_chk = 1'b1;
        endcase
    end

    // Bus slave next values; address and data are taken in any order
    always_comb
    begin
        aw_have_next = aw_have_reg;
        w_have_next  = w_have_reg;
        awaddr_next  = awaddr_reg;
        wdata_next   = wdata_reg;
        wstrb_next   = wstrb_reg;
        bvalid_next  = bvalid_reg && !s_axi_bready_i;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg && !s_axi_rready_i;
        rresp_next   = rresp_reg;
        rdata_next   = rdata_reg;
        s_axi_awready_o = !aw_have_reg && !bvalid_reg;
        s_axi_wready_o  = !w_have_reg && !bvalid_reg;
        s_axi_arready_o = !rvalid_reg;
        if (s_axi_awvalid_i && s_axi_awready_o)
        begin
            aw_have_next = 1'b1;
            awaddr_next  = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o)
        begin
            w_have_next = 1'b1;
            wdata_next  = s_axi_wdata_i;
            wstrb_next  = s_axi_wstrb_i;
        end
        if (do_write)
        begin
            aw_have_next = 1'b0;
            w_have_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = (wofs == flash_cmd_pkg::OFS_STATUS
                            || wofs == flash_cmd_pkg::OFS_INDEX
                            || wofs == flash_cmd_pkg::OFS_WORD)
                           ? flash_cmd_pkg::RESP_OKAY
                           : flash_cmd_pkg::RESP_SLVERR;
        end
        if (s_axi_arvalid_i && s_axi_arready_o)
        begin
            rvalid_next = 1'b1;
            rresp_next  = flash_cmd_pkg::RESP_OKAY;
            rdata_next  = 32'h0000_0000;
            case (8'(s_axi_araddr_i))
                flash_cmd_pkg::OFS_STATUS: rdata_next[7:0] = stat_reg;
                flash_cmd_pkg::OFS_INDEX:  rdata_next[2:0] = index_reg;
                flash_cmd_pkg::OFS_WORD:
                    if (index_reg <= flash_cmd_pkg::IDX_DATA)
                        rdata_next[15:0] = word_reg[index_reg];
                default: rresp_next = flash_cmd_pkg::RESP_SLVERR;
            endcase
        end
    end

    // Command registers and executor next values
    always_comb
    begin
        state_next   = state_reg;
        kind_next    = kind_reg;
        stat_next    = stat_reg;
        index_next   = index_reg;
        word_next    = word_reg;
        start_next   = 1'b0;
        opaddr_next  = opaddr_reg;
        opdata_next  = opdata_reg;
        release_next = 1'b0;
        // Access and violation flags clear by writing one; a set below wins
        if (do_write && wofs == flash_cmd_pkg::OFS_STATUS && wstrb_reg[0])
        begin
            stat_next[flash_cmd_pkg::BIT_ACC] =
                stat_reg[flash_cmd_pkg::BIT_ACC]
                && !wdata_reg[flash_cmd_pkg::BIT_ACC];
            stat_next[flash_cmd_pkg::BIT_VIOL] =
                stat_reg[flash_cmd_pkg::BIT_VIOL]
                && !wdata_reg[flash_cmd_pkg::BIT_VIOL];
        end
        // Command words are frozen while a command runs
        if (do_write && !busy && wofs == flash_cmd_pkg::OFS_INDEX
            && wstrb_reg[0])
            index_next = wdata_reg[2:0];
        if (do_write && !busy && wofs == flash_cmd_pkg::OFS_WORD
            && index_reg <= flash_cmd_pkg::IDX_DATA)
            word_next[index_reg] = merge16(word_reg[index_reg],
                                           wdata_reg, wstrb_reg);
        if (launch)
        begin
            stat_next[flash_cmd_pkg::BIT_DONE] = 1'b0; // RULE_20
            stat_next[flash_cmd_pkg::BIT_VERR] = 1'b0;
            stat_next[flash_cmd_pkg::BIT_UNC]  = 1'b0;
            state_next = flash_cmd_pkg::ST_CHECK;
        end
        case (state_reg)
            flash_cmd_pkg::ST_IDLE: ;
            flash_cmd_pkg::ST_CHECK:
            begin
                opaddr_next = code == flash_cmd_pkg::CMD_OTP
                              ? {20'h0_0000, word_reg[1][2:0]} : gaddr;
                opdata_next = {word_reg[5], word_reg[4],
                               word_reg[3], word_reg[2]};
                if (acc_chk || viol_chk)
                begin
                    stat_next[flash_cmd_pkg::BIT_ACC]  = acc_chk;
                    stat_next[flash_cmd_pkg::BIT_VIOL] =
                        !acc_chk && viol_chk; // RULE_03 RULE_15
                    stat_next[flash_cmd_pkg::BIT_DONE] = 1'b1; // RULE_24
                    state_next = flash_cmd_pkg::ST_IDLE;
                end
                else
                begin
                    start_next = 1'b1;
                    kind_next  = chk_kind_o; // RULE_22 RULE_16
                    state_next = flash_cmd_pkg::ST_RUN;
                    if (code == flash_cmd_pkg::CMD_OTP)
                    begin
                        kind_next  = flash_cmd_pkg::OP_OTP_BLANK; // RULE_06
                        state_next = flash_cmd_pkg::ST_BLANK;
                    end
                end
            end
            flash_cmd_pkg::ST_BLANK:
                // An all-ones phrase passes the blank check
                if (op_done_i)
                begin
                    if (op_verr_i || op_uncorr_i) // RULE_07 RULE_08
                    begin
                        stat_next[flash_cmd_pkg::BIT_ACC]  = 1'b1;
                        stat_next[flash_cmd_pkg::BIT_DONE] = 1'b1;
                        state_next = flash_cmd_pkg::ST_IDLE;
                    end
                    else
                    begin
                        start_next = 1'b1; // RULE_06
                        kind_next  = flash_cmd_pkg::OP_OTP_PROG;
                        state_next = flash_cmd_pkg::ST_RUN;
                    end
                end
            flash_cmd_pkg::ST_RUN:
                if (op_done_i)
                begin
                    stat_next[flash_cmd_pkg::BIT_VERR] = op_verr_i; // RULE_04
                    stat_next[flash_cmd_pkg::BIT_UNC]  = op_uncorr_i;
                    stat_next[flash_cmd_pkg::BIT_DONE] = 1'b1; // RULE_20
                    // Security held unless the whole erase verified
                    release_next =
                        kind_reg == flash_cmd_pkg::OP_ERASE_ALL
                        && !op_verr_i && !op_uncorr_i; // RULE_10 RULE_18 RULE_19
                    state_next = flash_cmd_pkg::ST_IDLE;
                end
            default: state_next = flash_cmd_pkg::ST_IDLE;
        endcase
        b0busy_next = code == flash_cmd_pkg::CMD_OTP
                      && (state_next == flash_cmd_pkg::ST_BLANK
                          || state_next == flash_cmd_pkg::ST_RUN); // RULE_09
    end

    // Register stage
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            state_reg   <= flash_cmd_pkg::ST_IDLE;
            kind_reg    <= flash_cmd_pkg::OP_PROG;
            stat_reg    <= flash_cmd_pkg::STATUS_RST;
            index_reg   <= flash_cmd_pkg::INDEX_RST;
            for (int i = 0; i < flash_cmd_pkg::NUM_WORDS; i++)
                word_reg[i] <= flash_cmd_pkg::WORD_RST;
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            awaddr_reg  <= '0;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= flash_cmd_pkg::RESP_OKAY;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= flash_cmd_pkg::RESP_OKAY;
            rdata_reg   <= 32'h0000_0000;
            start_reg   <= 1'b0;
            opaddr_reg  <= 23'h00_0000;
            opdata_reg  <= 64'h0000_0000_0000_0000;
            release_reg <= 1'b0;
            b0busy_reg  <= 1'b0;
        end
        else
        begin
            state_reg   <= state_next;
            kind_reg    <= kind_next;
            stat_reg    <= stat_next;
            index_reg   <= index_next;
            word_reg    <= word_next;
            aw_have_reg <= aw_have_next;
            w_have_reg  <= w_have_next;
            awaddr_reg  <= awaddr_next;
            wdata_reg   <= wdata_next;
            wstrb_reg   <= wstrb_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            rvalid_reg  <= rvalid_next;
            rresp_reg   <= rresp_next;
            rdata_reg   <= rdata_next;
            start_reg   <= start_next;
            opaddr_reg  <= opaddr_next;
            opdata_reg  <= opdata_next;
            release_reg <= release_next;
            b0busy_reg  <= b0busy_next;
        end
    end

    // Outputs straight from flip-flops
    assign s_axi_bvalid_o   = bvalid_reg;
    assign s_axi_bresp_o    = bresp_reg;
    assign s_axi_rvalid_o   = rvalid_reg;
    assign s_axi_rresp_o    = rresp_reg;
    assign s_axi_rdata_o    = rdata_reg;
    assign op_start_o       = start_reg;
    assign op_kind_o        = kind_reg;
    assign op_addr_o        = opaddr_reg;
    assign op_data_o        = opdata_reg;
    assign secure_release_o = release_reg;
    assign block0_busy_o    = b0busy_reg;

    // Checks on the executor
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_launch_busy: assert property (launch |=> busy) // RULE_20
        else $error("done flag not cleared on launch");
    a_check_refuse: assert property (
        state_reg == flash_cmd_pkg::ST_CHECK && acc_chk
        |=> !op_start_o && !busy && stat_reg[flash_cmd_pkg::BIT_ACC]) // RULE_24
        else $error("refused launch started or stayed busy");
    a_prog_align: assert property (
        state_reg == flash_cmd_pkg::ST_CHECK
        && code == flash_cmd_pkg::CMD_PROG && gaddr[2:0] != 3'h0
        |=> stat_reg[flash_cmd_pkg::BIT_ACC]) // RULE_02
        else $error("misaligned program not refused");
    a_prog_index: assert property (
        state_reg == flash_cmd_pkg::ST_CHECK
        && code == flash_cmd_pkg::CMD_PROG
        && index_reg != flash_cmd_pkg::IDX_DATA
        |=> stat_reg[flash_cmd_pkg::BIT_ACC] && !op_start_o) // RULE_01
        else $error("program with wrong index not refused");
    a_otp_no_viol: assert property (
        state_reg == flash_cmd_pkg::ST_CHECK
        && code == flash_cmd_pkg::CMD_OTP
        |=> !stat_reg[flash_cmd_pkg::BIT_VIOL]) // RULE_07
        else $error("violation flagged for one-time program");
    a_otp_blank: assert property (
        op_start_o && op_kind_o == flash_cmd_pkg::OP_OTP_PROG
        |-> $past(state_reg) == flash_cmd_pkg::ST_BLANK) // RULE_06
        else $error("one-time program without blank check");
    a_prot_stop: assert property (
        state_reg == flash_cmd_pkg::ST_CHECK && !acc_chk && viol_chk
        |=> stat_reg[flash_cmd_pkg::BIT_VIOL] && !op_start_o
            ##1 !op_start_o) // RULE_03
        else $error("protected target was operated on");
    a_verify_flag: assert property (
        state_reg == flash_cmd_pkg::ST_RUN && op_done_i
        |=> stat_reg[flash_cmd_pkg::BIT_VERR] == $past(op_verr_i)
            && stat_reg[flash_cmd_pkg::BIT_UNC] == $past(op_uncorr_i)
            && !busy) // RULE_04
        else $error("verify result not reported");
    a_unsec_fail: assert property (
        state_reg == flash_cmd_pkg::ST_RUN && op_done_i && op_verr_i
        |=> !secure_release_o) // RULE_19
        else $error("security released after failed verify");
    a_block0_busy: assert property (
        op_start_o && op_kind_o == flash_cmd_pkg::OP_OTP_BLANK
        |-> block0_busy_o) // RULE_09
        else $error("block 0 busy not shown");

    c_prog_done: cover property (
        op_start_o && op_kind_o == flash_cmd_pkg::OP_PROG
        ##[1:50] state_reg == flash_cmd_pkg::ST_RUN && op_done_i);
    c_otp_full: cover property (
        op_start_o && op_kind_o == flash_cmd_pkg::OP_OTP_PROG);
    c_release: cover property (secure_release_o);
    c_refused: cover property (
        state_reg == flash_cmd_pkg::ST_CHECK && acc_chk);

endmodule

/* File: testbench/flash_seq_model.sv */
// Behavioural flash array sequencer answering each start
`timescale 1ns/10ps
module flash_seq_model (
    input  wire logic clk_i,
    input  wire logic op_start_i,
    output logic      op_done_o
);
    logic [3:0] cnt_reg = 4'h0;
    // Six cycles per operation with its verify, so done is never instant
    always_ff @(posedge clk_i)
        cnt_reg <= op_start_i ? 4'h6 : cnt_reg - {3'h0, |cnt_reg};
    assign op_done_o = cnt_reg == 4'h1;
endmodule

/* File: testbench/flash_cmd_exec_test.sv */
// Register-level bench of the flash command executor
`timescale 1ns/10ps
module flash_cmd_exec_test;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, deny, prot, aprot, fail, unc, awv;
    logic wv, arv, bry, rry, awr, wr_r, arr, bv, rv, start, done;
    logic rel, b0, b0_seen = 1'b0;
    logic [2:0] kind;
    logic [22:0] caddr, oaddr;
    logic [31:0] kind_seen, addr_seen;
    logic [63:0] odata, data_seen;
    logic [1:0] bresp, rresp, resp;
    logic [7:0] adr;
    logic [31:0] wd, rd_d, rdat;
    int err_total = 0, n_compared = 0, cyc = 0, n_rel = 0;
    // Upper address 7F is a hole in the map; bit 22 set means data flash
    flash_cmd_exec i_flash_cmd_exec (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .s_axi_awaddr_i(adr), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
        .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
        .s_axi_wready_o(wr_r), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
        .s_axi_bready_i(bry), .s_axi_araddr_i(adr), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(arr), .s_axi_rdata_o(rd_d), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .cmd_allow_i({16{!deny}}),
        .chk_addr_o(caddr), .chk_kind_o(),
        .chk_addr_valid_i(caddr[22:16] != 7'h7F), .chk_pflash_i(!caddr[22]),
        .chk_prot_i(prot), .any_prot_i(aprot), .op_start_o(start),
        .op_kind_o(kind), .op_addr_o(oaddr), .op_data_o(odata),
        .op_done_i(done), .op_verr_i(done & fail), .op_uncorr_i(done & unc),
        .secure_release_o(rel), .block0_busy_o(b0));
    flash_seq_model i_flash_seq_model (.clk_i(clk_i), .op_start_i(start),
        .op_done_o(done));
    // 4 ns clock; a hung wait is cut short by the cycle ceiling
    always #2 clk_i = ~clk_i;
    // Outputs are sampled at the falling edge, where they have settled
    always @(negedge clk_i)
    begin
        if (start) kind_seen <= {29'h0, kind};
        if (start) {addr_seen, data_seen} <= {9'h000, oaddr, odata};
        if (rel) n_rel++;
        if (b0) b0_seen <= 1'b1;
    end
    always @(posedge clk_i)
        if (++cyc == 20000) tally_and_finish(1);
    task automatic check(input string n, input logic [31:0] s, e);
        n_compared++;
        if (s !== e) err_total++;
        if (s !== e) $display("ERROR %s expected %h seen %h", n, e, s);
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        logic [3:0] h = 4'h0;
        {adr, wd} <= {a, d};
        {awv, wv, arv, bry, rry} <= {w, w, !w, w, !w};
        while (!h[0])
        begin
            @(negedge clk_i);
            h = {awv & !awr, wv & !wr_r, arv & !arr, w ? bv : rv};
            {rdat, resp} = {rd_d, w ? bresp : rresp};
            @(posedge clk_i);
            {awv, wv, arv} <= h[3:1];
        end
        @(posedge clk_i);
    endtask
    task automatic cmd(input logic [15:0] w0, w1, input logic [2:0] ix,
                       input logic [4:0] f, input logic [7:0] e);
        {unc, deny, aprot, prot, fail} <= f;
        bus(1'b1, flash_cmd_pkg::OFS_INDEX, 32'h0000_0000);
        bus(1'b1, flash_cmd_pkg::OFS_WORD, {16'h0000, w0});
        bus(1'b1, flash_cmd_pkg::OFS_INDEX, 32'h0000_0001);
        bus(1'b1, flash_cmd_pkg::OFS_WORD, {16'h0000, w1});
        for (int i = 2; i < 6; i++)
        begin
            bus(1'b1, flash_cmd_pkg::OFS_INDEX, i);
            bus(1'b1, flash_cmd_pkg::OFS_WORD, 32'h0000_0D00 + i);
        end
        bus(1'b1, flash_cmd_pkg::OFS_INDEX, {29'h0, ix});
        bus(1'b1, flash_cmd_pkg::OFS_STATUS, 32'h0000_0080);
        do bus(1'b0, 8'h00, 32'h0000_0000); while (!rdat[7]);
        check("status", rdat, {24'h00_0000, e});
        bus(1'b1, flash_cmd_pkg::OFS_STATUS, 32'h0000_0030);
    endtask
    task automatic tally_and_finish(input int extra);
        if (err_total + extra == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Reset, then one command per line with its expected status
    initial
    begin
        {deny, prot, aprot, fail, unc, awv, wv, arv, bry, rry, adr, wd} = '0;
        repeat (16) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        bus(1'b0, 8'h0C, 32'h0000_0000);
        check("unmapped", {30'h0, resp}, 32'h0000_0002);
        cmd(16'h0600, 16'h0008, 3'h5, 5'h00, 8'h80);
        check("kind", kind_seen, 32'(flash_cmd_pkg::OP_PROG));
        check("addr", addr_seen, 32'h0000_0008);
        check("data hi", data_seen[63:32], 32'h0D05_0D04);
        check("data lo", data_seen[31:0], 32'h0D03_0D02);
        cmd(16'h0600, 16'h0003, 3'h5, 5'h00, 8'hA0);
        cmd(16'h067F, 16'h0008, 3'h5, 5'h00, 8'hA0);
        cmd(16'h0600, 16'h0008, 3'h4, 5'h00, 8'hA0);
        cmd(16'h0600, 16'h0008, 3'h5, 5'h02, 8'h90);
        cmd(16'h0600, 16'h0008, 3'h5, 5'h08, 8'hA0);
        cmd(16'h0600, 16'h0010, 3'h5, 5'h10, 8'h81);
        check("block0 idle", {31'h0, b0_seen}, 32'h0000_0000);
        cmd(16'h0700, 16'h0007, 3'h5, 5'h02, 8'h80);
        check("kind", kind_seen, 32'(flash_cmd_pkg::OP_OTP_PROG));
        check("addr", addr_seen, 32'h0000_0007);
        check("block0 busy", {31'h0, b0_seen}, 32'h0000_0001);
        cmd(16'h0700, 16'h0008, 3'h5, 5'h00, 8'hA0);
        cmd(16'h0700, 16'h0003, 3'h5, 5'h01, 8'hA0);
        cmd(16'h0800, 16'h0000, 3'h0, 5'h04, 8'h90);
        cmd(16'h0800, 16'h0000, 3'h0, 5'h00, 8'h80);
        cmd(16'h0B00, 16'h0000, 3'h0, 5'h01, 8'h82);
        check("release", n_rel, 1);
        cmd(16'h0B00, 16'h0000, 3'h0, 5'h00, 8'h80);
        check("release", n_rel, 2);
        cmd(16'h0900, 16'h0008, 3'h1, 5'h00, 8'h80);
        cmd(16'h0940, 16'h0002, 3'h1, 5'h00, 8'h80);
        cmd(16'h0900, 16'h0002, 3'h1, 5'h02, 8'hA0);
        cmd(16'h0900, 16'h0008, 3'h1, 5'h02, 8'h90);
        cmd(16'h0A00, 16'h0010, 3'h1, 5'h00, 8'h80);
        cmd(16'h0A00, 16'h0004, 3'h1, 5'h02, 8'hA0);
        tally_and_finish(0);
    end
endmodule
